// [src/lmrop_core.sv]
// Purpose: Execute or, move, store, literal load, no-op and interrupt return
// Assumes: File read data valid for the address of the current word
// Notes: Other opcodes are treated as no-ops; stack storage lives outside
//
// Function
// [RULE1] OR accumulator with file register, write destination, update zero flag
// [RULE2] File address 0..127; destination bit 0 to accumulator, 1 to file
// [RULE3] File move copies value unchanged to chosen destination in one cycle
// [RULE4] File move updates zero flag even when writing back to file
// [RULE5] Store accumulator to file, flags untouched, single cycle
// [RULE6] Literal load puts 8-bit literal in accumulator, flags untouched
// [RULE7] Interrupt return pops stack, loads top value into program counter
// [RULE8] Interrupt return sets global interrupt enable, control bit 7
// [RULE9] Interrupt return takes one word and two cycles
// [RULE10] Zero flag set when result is all zeros, else cleared
// [RULE11] No-op changes nothing but advances program counter
`timescale 1ns/1ps

module lmrop_core
    import lmrop_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // Instruction and operands
    input wire logic insn_valid_in,
    input wire logic [13:0] insn_in,
    input wire logic [7:0] file_rdata_in,
    input wire logic [12:0] top_of_return_stack_in,
    // File and stack side
    output lmrop_fwr_t file_wr_out,
    output logic stack_pop_out,
    // Core state
    output logic [7:0] acc_out,
    output logic zero_flag_out,
    output logic [7:0] interrupt_control_register_out,
    output logic [12:0] pc_out,
    output logic busy_out
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic lmrop_kind_t decode(input logic [13:0] w);
        lmrop_kind_t k;
        k = LMROP_K_NONE;
        if (w[13:8] == LMROP_OP_OR) begin
            k = LMROP_K_OR;
        end else if (w[13:8] == LMROP_OP_MOVE) begin
            k = LMROP_K_MOVE;
        end else if (w[13:7] == LMROP_OP_STORE) begin
            k = LMROP_K_STORE;
        end else if (w[13:10] == LMROP_OP_LIT) begin
            k = LMROP_K_LIT;
        end else if (w == LMROP_OP_NOP) begin
            k = LMROP_K_NOP;
        end else if (w == LMROP_OP_RET) begin
            k = LMROP_K_RET;
        end
        return k;
    endfunction

    lmrop_kind_t kind;
    logic [7:0] acc;
    logic zero_flag;
    logic [7:0] intctl;
    logic [12:0] pc;
    logic refill;
    lmrop_fwr_t fwr;
    logic pop;
    logic [7:0] next_acc;
    logic next_zero_flag;
    logic [7:0] next_intctl;
    logic [12:0] next_pc;
    logic next_refill;
    lmrop_fwr_t next_fwr;
    logic next_pop;
    logic [7:0] result;
    logic to_file;

    assign kind = decode(insn_in);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_acc = acc;
        next_zero_flag = zero_flag;
        next_intctl = intctl;
        next_pc = pc;
        next_refill = 1'b0;
        next_fwr = '0;
        next_pop = 1'b0;
        // [RULE2] destination and address
        to_file = insn_in[LMROP_DEST_BIT];
        result = file_rdata_in;
        if (refill) begin
            // [RULE9] Second cycle refills pipeline
            next_refill = 1'b0;
        end else if (insn_valid_in) begin
            next_pc = pc + 13'h0001;
            case (kind)
                LMROP_K_OR, LMROP_K_MOVE: begin
                    // [RULE1] OR with file
                    // [RULE3] move unchanged
                    result = (kind == LMROP_K_OR) ? (acc | file_rdata_in) : file_rdata_in;
                    // [RULE4] [RULE10] zero flag from result
                    next_zero_flag = (result == 8'h00);
                    if (to_file) begin
                        next_fwr = '{we: 1'b1, addr: insn_in[6:0], data: result};
                    end else begin
                        next_acc = result;
                    end
                end
                LMROP_K_STORE: begin
                    // [RULE5] store, flags kept
                    next_fwr = '{we: 1'b1, addr: insn_in[6:0], data: acc};
                end
                LMROP_K_LIT: begin
                    // [RULE6] literal load
                    next_acc = insn_in[7:0];
                end
                LMROP_K_RET: begin
                    // [RULE7] pop into program counter
                    next_pc = top_of_return_stack_in;
                    next_pop = 1'b1;
                    // [RULE8] reenable interrupts
                    next_intctl[LMROP_INT_EN_BIT] = 1'b1;
                    next_refill = 1'b1;
                end
                default: begin
                    // [RULE11] only counter advances
                    next_acc = acc;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc <= LMROP_ACC_RST;
            zero_flag <= LMROP_ZERO_RST;
            intctl <= LMROP_INTCTL_RST;
            pc <= LMROP_PC_RST;
            refill <= 1'b0;
            fwr <= '0;
            pop <= 1'b0;
        end else begin
            acc <= next_acc;
            zero_flag <= next_zero_flag;
            intctl <= next_intctl;
            pc <= next_pc;
            refill <= next_refill;
            fwr <= next_fwr;
            pop <= next_pop;
        end
    end

    assign acc_out = acc;
    assign zero_flag_out = zero_flag;
    assign interrupt_control_register_out = intctl;
    assign pc_out = pc;
    assign busy_out = refill;
    assign file_wr_out = fwr;
    assign stack_pop_out = pop;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    AST_OR_RESULT: assert property (insn_valid_in && !refill && kind == LMROP_K_OR // [RULE1]
        && !insn_in[LMROP_DEST_BIT] |=> acc == ($past(acc) | $past(file_rdata_in)))
        else $error("or result wrong");
    AST_DEST_FILE: assert property (insn_valid_in && !refill // [RULE2]
        && (kind == LMROP_K_OR || kind == LMROP_K_MOVE) && insn_in[LMROP_DEST_BIT]
        |=> fwr.we && fwr.addr == $past(insn_in[6:0]) && acc == $past(acc))
        else $error("file destination wrong");
    AST_MOVE_COPY: assert property (insn_valid_in && !refill && kind == LMROP_K_MOVE // [RULE3]
        && !insn_in[LMROP_DEST_BIT] |=> acc == $past(file_rdata_in) && !busy_out)
        else $error("move not copied");
    AST_MOVE_ZERO: assert property (insn_valid_in && !refill && kind == LMROP_K_MOVE // [RULE4]
        && insn_in[LMROP_DEST_BIT] |=> zero_flag == (fwr.data == 8'h00))
        else $error("move zero flag wrong");
    AST_STORE: assert property (insn_valid_in && !refill && kind == LMROP_K_STORE // [RULE5]
        |=> fwr.we && fwr.data == $past(acc) && $stable(zero_flag))
        else $error("store wrong");
    AST_LITERAL: assert property (insn_valid_in && !refill && kind == LMROP_K_LIT // [RULE6]
        |=> acc == $past(insn_in[7:0]) && $stable(zero_flag))
        else $error("literal load wrong");
    AST_RETURN_PC: assert property (insn_valid_in && !refill && kind == LMROP_K_RET // [RULE7]
        |=> pc == $past(top_of_return_stack_in) && pop ##1 !pop)
        else $error("return pc wrong");
    AST_RETURN_FLAGS: assert property (insn_valid_in && !refill && kind == LMROP_K_RET // [RULE7]
        |=> $stable(zero_flag) && $stable(acc) && !fwr.we)
        else $error("return changed flags");
    AST_RETURN_GIE: assert property (insn_valid_in && !refill && kind == LMROP_K_RET // [RULE8]
        |=> intctl[LMROP_INT_EN_BIT])
        else $error("enable not set");
    AST_RETURN_TWO: assert property (insn_valid_in && !refill && kind == LMROP_K_RET // [RULE9]
        |=> busy_out ##1 !busy_out)
        else $error("return not two cycles");
    // Fetch side must hold its word; anything offered in refill is lost
    AST_REFILL_HOLD: assert property (refill // [RULE9]
        |=> $stable(pc) && $stable(acc) && $stable(zero_flag) && !fwr.we && !pop)
        else $error("word taken during refill");
    AST_ZERO_RULE: assert property (insn_valid_in && !refill && kind == LMROP_K_OR // [RULE10]
        |=> zero_flag == (($past(acc) | $past(file_rdata_in)) == 8'h00))
        else $error("zero flag rule broken");
    AST_NOP: assert property (insn_valid_in && !refill && kind == LMROP_K_NOP // [RULE11]
        |=> pc == $past(pc) + 13'h0001 && $stable(acc) && !fwr.we)
        else $error("no-op changed state");
    AST_UNKNOWN_OP: assert property (insn_valid_in && !refill && kind == LMROP_K_NONE // [RULE11]
        |=> pc == $past(pc) + 13'h0001 && $stable(acc) && $stable(zero_flag) && !fwr.we && !pop)
        else $error("unknown word changed state");

    COV_IOR: cover property (insn_valid_in && kind == LMROP_K_OR);
    COV_MOVE_ZERO: cover property (insn_valid_in && kind == LMROP_K_MOVE ##1 zero_flag);
    COV_RETURN: cover property (insn_valid_in && kind == LMROP_K_RET ##2 insn_valid_in);
    COV_STORE: cover property (insn_valid_in && !refill && kind == LMROP_K_STORE);
    COV_LIT_ZERO: cover property (insn_valid_in && kind == LMROP_K_LIT && insn_in[7:0] == 8'h00);

endmodule

// [pkg/lmrop_pkg.sv]
// Purpose: Constants and carriers for the logic, move and return execution unit
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes: Opcode values are fixed by the instruction set encoding

package lmrop_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int LMROP_DATA_W = 8;
    localparam int LMROP_ADDR_W = 7;
    localparam int LMROP_PC_W = 13;
    localparam int LMROP_INSN_W = 14;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [5:0] LMROP_OP_OR = 6'h04;
    localparam logic [5:0] LMROP_OP_MOVE = 6'h08;
    localparam logic [6:0] LMROP_OP_STORE = 7'h01;
    localparam logic [3:0] LMROP_OP_LIT = 4'hc;
    localparam logic [13:0] LMROP_OP_NOP = 14'h0000;
    localparam logic [13:0] LMROP_OP_RET = 14'h0009;
    localparam int LMROP_DEST_BIT = 7;
    localparam int LMROP_INT_EN_BIT = 7;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] LMROP_ACC_RST = 8'h00;
    localparam logic [12:0] LMROP_PC_RST = 13'h0000;
    localparam logic [7:0] LMROP_INTCTL_RST = 8'h00;
    localparam logic LMROP_ZERO_RST = 1'b0;

    typedef enum logic [2:0] {
        LMROP_K_NONE,
        LMROP_K_OR,
        LMROP_K_MOVE,
        LMROP_K_STORE,
        LMROP_K_LIT,
        LMROP_K_NOP,
        LMROP_K_RET
    } lmrop_kind_t;

    // File write request toward the register file
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } lmrop_fwr_t;

endpackage

// [testbench/test_logic_move_return_ops.sv]
// Purpose: Random and directed check of the execution unit
// Assumes: Results registered at the taking edge, one refill cycle after return
// Notes: Reference state is kept in the bench, compared at each falling edge
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end

module test_logic_move_return_ops
    import lmrop_pkg::*;
;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic insn_valid_in = 1'b0;
    logic [13:0] insn_in = 14'h0000;
    logic [7:0] file_rdata_in = 8'h00;
    logic [12:0] top_of_return_stack_in = 13'h0000;
    lmrop_fwr_t file_wr_out;
    logic stack_pop_out, zero_flag_out, busy_out;
    logic [7:0] acc_out, interrupt_control_register_out;
    logic [12:0] pc_out;
    logic [7:0] e_acc = 8'h00, e_ictl = 8'h00, e_data, r8;
    logic [12:0] e_pc = 13'h0000;
    logic [6:0] e_addr;
    logic e_z = 1'b0, e_busy = 1'b0, e_we = 1'b0, e_pop = 1'b0, e_d;
    logic [31:0] r, r2;
    logic [13:0] dir [4] = '{14'h3300, 14'h04ff, 14'h0009, 14'h08ff};
    integer seed = 32'h9386;
    int err_count = 0;
    int comparisons = 0;

    lmrop_core dut (.clock_in(clock_in), .resetn_in(resetn_in), .insn_valid_in(insn_valid_in),
        .insn_in(insn_in), .file_rdata_in(file_rdata_in),
        .top_of_return_stack_in(top_of_return_stack_in), .file_wr_out(file_wr_out),
        .stack_pop_out(stack_pop_out), .acc_out(acc_out), .zero_flag_out(zero_flag_out),
        .interrupt_control_register_out(interrupt_control_register_out),
        .pc_out(pc_out), .busy_out(busy_out));

    always #50 clock_in = ~clock_in;

    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    // Uses the word applied at the previous edge, before new drives land
    task automatic model_step();
        e_we = 1'b0;
        e_pop = 1'b0;
        e_d = insn_in[LMROP_DEST_BIT];
        if (insn_valid_in && !e_busy) begin
            e_pc = e_pc + 13'h0001;
            if (insn_in[13:8] == LMROP_OP_OR || insn_in[13:8] == LMROP_OP_MOVE) begin
                r8 = (insn_in[13:8] == LMROP_OP_OR) ? (e_acc | file_rdata_in) : file_rdata_in;
                e_z = (r8 == 8'h00);
                if (e_d) begin
                    {e_we, e_addr, e_data} = {1'b1, insn_in[6:0], r8};
                end else begin
                    e_acc = r8;
                end
            end else if (insn_in[13:7] == LMROP_OP_STORE) begin
                {e_we, e_addr, e_data} = {1'b1, insn_in[6:0], e_acc};
            end else if (insn_in[13:10] == LMROP_OP_LIT) begin
                e_acc = insn_in[7:0];
            end else if (insn_in == LMROP_OP_RET) begin
                {e_pc, e_pop, e_busy} = {top_of_return_stack_in, 2'b11};
                e_ictl[LMROP_INT_EN_BIT] = 1'b1;
            end
        end else begin
            e_busy = 1'b0;
        end
    endtask

    task automatic drive_next(input int i);
        r = $random(seed);
        r2 = $random(seed);
        if (i < 4) begin
            // Corners: don't-care literal bits, zero result, word refused in refill
            insn_in <= dir[i];
            insn_valid_in <= 1'b1;
            file_rdata_in <= 8'h00;
        end else begin
            case (r[2:0])
                3'h0, 3'h6: insn_in <= {LMROP_OP_OR, r[7:0]};
                3'h1: insn_in <= {LMROP_OP_MOVE, r[7:0]};
                3'h2: insn_in <= {LMROP_OP_STORE, r[6:0]};
                3'h3: insn_in <= {LMROP_OP_LIT, r2[1:0], (r[27:26] == 2'b00) ? 8'h00 : r2[15:8]};
                3'h7: insn_in <= {2'b11, r2[3:0], r2[15:8]};
                3'h4: insn_in <= LMROP_OP_NOP;
                default: insn_in <= LMROP_OP_RET;
            endcase
            insn_valid_in <= (r[31:29] != 3'h0);
            file_rdata_in <= (r[17:16] == 2'b00) ? 8'h00 : r[25:18];
            top_of_return_stack_in <= r2[28:16];
        end
    endtask

    task automatic check_all();
        `CHK(acc_out, e_acc)
        `CHK(zero_flag_out, e_z)
        `CHK(pc_out, e_pc)
        `CHK(interrupt_control_register_out, e_ictl)
        `CHK(busy_out, e_busy)
        `CHK(stack_pop_out, e_pop)
        `CHK(file_wr_out.we, e_we)
        if (e_we) `CHK({file_wr_out.addr, file_wr_out.data}, {e_addr, e_data})
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 800; i++) begin
            @(posedge clock_in);
            model_step();
            drive_next(i);
            @(negedge clock_in);
            check_all();
        end
        stop_test();
    end

    // Bound well above the 806 cycles the sequence needs
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
endmodule
